//--- pkg/port_cfg.svh
// Register map, reset values and bit positions of the eight-pin segment-muxed port
// Behaviour
// RULE1: Eight pins, each usable as input or output
// RULE2: Per-pin direction bit and output latch bit
// RULE3: Direction 0 drives latch; 1 reads pin
// RULE4: Writing pin level register updates latches
// RULE5: Each pin has own segment enable bit
// RULE6: Port function only while segment disabled
// RULE7: Segment overrides all; bits0-3 segments 47-44
// RULE8: Bit4 segment 40, bit5 segment 41
// RULE9: Capcomp nine/eight outputs beat latch, else capture
// RULE10: Enhanced PWM C/B outputs, optional shutdown tristate
// RULE11: Reset defaults pins to analog channels listed
// RULE12: Analog select leaves digital input path alone
// RULE13: Bits4/5 feed comparator two, direction-independent
// RULE14: Port present only in large configuration
// RULE15: Latch register reads stored latch values
// RULE16: Reset sets directions to input, analog on
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

// Byte offsets inside the block window
`define OFS_PIN_LEVEL 8'h00
`define OFS_OUTPUT_LATCH 8'h04
`define OFS_DIRECTION 8'h08
`define OFS_SEGMENT_ENABLE 8'h0C
`define OFS_ANALOG_LOW 8'h10
`define OFS_ANALOG_HIGH 8'h14
`define OFS_HIZ_CONFIG 8'h18

// Reset values
`define RST_DIRECTION 8'hFF
`define RST_LATCH 8'h00
`define RST_SEGMENT_ENABLE 8'h00
`define RST_ANALOG_LOW 8'hFF
`define RST_ANALOG_HIGH 8'hFF
`define RST_HIZ_CONFIG 8'h00

// Pins shared with capture/compare and comparator two
`define BIT_CAPCOMP_NINE 4
`define BIT_CAPCOMP_EIGHT 5

// Shutdown tristate configuration fields
`define HIZ_C_BIT 0
`define HIZ_B_BIT 1

// Pins below this index take segments counted downward
`define SEG_SPLIT_PIN 4

`endif

//--- pkg/port_pkg.sv
// Types shared by the port top and its pin multiplexer
`default_nettype none
package port_pkg;
	// Bus word
	typedef logic [31:0] word_t;
	// Bus slave phases
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_RD_WAIT = 2'b10,
		ST_RD_DONE = 2'b11
	} bus_state_t;
endpackage
`default_nettype wire

//--- pkg/pin_mux_if.sv
// Carrier between the port control logic and the pin multiplexer
`timescale 1ns/1ns
`default_nettype none
interface pin_mux_if #(parameter int PIN_COUNT = 8);
	logic [PIN_COUNT-1:0] seg_en; // Segment enabled per pin
	logic [PIN_COUNT-1:0] seg_val; // Segment drive per pin
	logic [PIN_COUNT-1:0] dir; // Direction, 1 is input
	logic [PIN_COUNT-1:0] latch; // Output latch
	logic [PIN_COUNT-1:0] alt_en; // Peripheral output active
	logic [PIN_COUNT-1:0] alt_val; // Peripheral output value
	logic [PIN_COUNT-1:0] alt_hiz; // Peripheral asks for tristate
	logic [PIN_COUNT-1:0] drv_val; // Resulting pin value
	logic [PIN_COUNT-1:0] drv_en; // Resulting pin enable
	// Control side
	modport ctrl (output seg_en, seg_val, dir, latch, alt_en, alt_val, alt_hiz,
		input drv_val, drv_en);
	// Multiplexer side
	modport mux (input seg_en, seg_val, dir, latch, alt_en, alt_val, alt_hiz,
		output drv_val, drv_en);
endinterface
`default_nettype wire

//--- hdl/port_pin_mux.sv
// Per-pin output priority: segment, then peripheral, then latch
`timescale 1ns/1ns
`default_nettype none
module port_pin_mux #(
	parameter int PIN_COUNT = 8
) (
	// Pin control and result
	pin_mux_if.mux pm
);
	import port_pkg::*;

	// One copy of the priority chain per pin
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
		always_comb begin
			if (pm.seg_en[i]) begin
				// Segment takes the pin over whatever else is set
				pm.drv_en[i] = 1'b1; // RULE7
				pm.drv_val[i] = pm.seg_val[i]; // RULE7
			end else if (!pm.dir[i]) begin
				// Output direction; shutdown may float the pin
				if (pm.alt_hiz[i]) begin
					pm.drv_en[i] = 1'b0; // RULE10
					pm.drv_val[i] = 1'b0;
				end else begin
					pm.drv_en[i] = 1'b1; // RULE3
					// Peripheral output wins over latch data
					pm.drv_val[i] = pm.alt_en[i] ? pm.alt_val[i] : pm.latch[i]; // RULE9
				end
			end else begin
				// Input direction leaves the pin undriven
				pm.drv_en[i] = 1'b0; // RULE3
				pm.drv_val[i] = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- hdl/gpio_port_segmux.sv
// Eight-pin bidirectional port with segment, analog and peripheral sharing
`timescale 1ns/1ns
`default_nettype none
`include "port_cfg.svh"
module gpio_port_segmux #(
	parameter bit PORT_PRESENT = 1'b1, // Large package configuration
	parameter int PIN_COUNT = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire port_pkg::word_t haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire port_pkg::word_t hwdata_i,
	input wire logic hready_i,
	output port_pkg::word_t hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Port pins
	input wire logic [PIN_COUNT-1:0] pin_i,
	output logic [PIN_COUNT-1:0] pin_o,
	output logic [PIN_COUNT-1:0] pin_oe_o,
	// Segment drives, index is segment number minus 40
	input wire logic [PIN_COUNT-1:0] segment_drive_i,
	// Capture/compare channels nine and eight
	input wire logic capcomp_channel_nine_out_i,
	input wire logic capcomp_channel_nine_en_i,
	input wire logic capcomp_channel_eight_out_i,
	input wire logic capcomp_channel_eight_en_i,
	output logic capcomp_channel_nine_capture_o,
	output logic capcomp_channel_eight_capture_o,
	// Enhanced PWM three outputs C and B
	input wire logic epwm_three_out_c_i,
	input wire logic epwm_three_out_c_en_i,
	input wire logic epwm_three_out_b_i,
	input wire logic epwm_three_out_b_en_i,
	input wire logic epwm_shutdown_i,
	// Comparator two inputs
	output logic comparator_two_in_c_o,
	output logic comparator_two_in_d_o,
	// Analog channel select per pin
	output logic [PIN_COUNT-1:0] analog_sel_o
);
	import port_pkg::*;

	// Software-visible registers
	logic [PIN_COUNT-1:0] port_output_latch_q; // Output latch
	logic [PIN_COUNT-1:0] port_direction_q; // Direction, 1 is input
	logic [7:0] segment_enable_group_five_q; // Segments 40 to 47
	logic [7:0] analog_select_low_q; // Channels 8 to 15
	logic [7:0] analog_select_high_q; // Channels 16 to 23
	logic [7:0] hiz_config_q; // Shutdown tristate choice
	// Sampled pin levels
	logic [PIN_COUNT-1:0] pin_level_q;
	// Bus slave state
	bus_state_t state_q;
	logic [7:0] addr_q; // Captured address offset
	logic size_ok_q; // Captured size was a whole word
	word_t hrdata_q;
	logic hready_q;
	// Registered outputs
	logic [PIN_COUNT-1:0] pin_o_q;
	logic [PIN_COUNT-1:0] pin_oe_q;
	logic nine_cap_q;
	logic eight_cap_q;
	logic comp_c_q;
	logic comp_d_q;
	logic [PIN_COUNT-1:0] analog_sel_q;
	// Per-pin decoded controls
	logic [PIN_COUNT-1:0] seg_en_pin;
	logic [PIN_COUNT-1:0] ana_pin;
	// Address phase taken this edge
	logic take_addr;

	// Multiplexer carrier
	pin_mux_if #(.PIN_COUNT(PIN_COUNT)) pm ();

	// Segment enable bit serving a pin: low pins count down from 47
	function automatic int seg_bit(input int pin);
		if (pin < `SEG_SPLIT_PIN) begin
			return 7 - pin; // RULE7
		end else begin
			return pin - `SEG_SPLIT_PIN; // RULE8
		end
	endfunction

	// Analog select bit for a pin, positions 8 and up mean the high register
	function automatic int ana_bit(input int pin);
		if (pin < `SEG_SPLIT_PIN) begin
			return 15 - pin; // RULE11
		end else begin
			return pin; // RULE11
		end
	endfunction

	// Decode segment and analog selects for every pin
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_decode
		localparam int SB = seg_bit(i);
		localparam int AB = ana_bit(i);
		assign seg_en_pin[i] = segment_enable_group_five_q[SB]; // RULE5
		if (AB > 7) begin : g_high
			assign ana_pin[i] = analog_select_high_q[AB-8];
		end else begin : g_low
			assign ana_pin[i] = analog_select_low_q[AB];
		end
		assign pm.seg_val[i] = segment_drive_i[SB];
	end

	// Feed the multiplexer from registers and peripherals
	assign pm.seg_en = seg_en_pin; // RULE6
	assign pm.dir = port_direction_q; // RULE2
	assign pm.latch = port_output_latch_q;
	always_comb begin
		pm.alt_en = '0;
		pm.alt_val = '0;
		pm.alt_hiz = '0;
		// Channel nine first, enhanced PWM C behind it
		pm.alt_en[`BIT_CAPCOMP_NINE] = capcomp_channel_nine_en_i | epwm_three_out_c_en_i; // RULE9
		pm.alt_val[`BIT_CAPCOMP_NINE] = capcomp_channel_nine_en_i ?
			capcomp_channel_nine_out_i : epwm_three_out_c_i; // RULE10
		pm.alt_hiz[`BIT_CAPCOMP_NINE] = !capcomp_channel_nine_en_i & epwm_three_out_c_en_i &
			epwm_shutdown_i & hiz_config_q[`HIZ_C_BIT]; // RULE10
		// Channel eight first, enhanced PWM B behind it
		pm.alt_en[`BIT_CAPCOMP_EIGHT] = capcomp_channel_eight_en_i | epwm_three_out_b_en_i; // RULE9
		pm.alt_val[`BIT_CAPCOMP_EIGHT] = capcomp_channel_eight_en_i ?
			capcomp_channel_eight_out_i : epwm_three_out_b_i; // RULE10
		pm.alt_hiz[`BIT_CAPCOMP_EIGHT] = !capcomp_channel_eight_en_i & epwm_three_out_b_en_i &
			epwm_shutdown_i & hiz_config_q[`HIZ_B_BIT]; // RULE10
	end

	// Pin priority chain
	port_pin_mux #(.PIN_COUNT(PIN_COUNT)) u_mux (
		.pm(pm.mux)
	);

	// A valid transfer starts when selected, non-idle and bus ready
	assign take_addr = hsel_i & htrans_i[1] & hready_i;

	// Pins are synchronous; one register stage for the read path
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_level_q <= '0;
		end else begin
			// Digital input path is never gated by analog selects
			pin_level_q <= pin_i; // RULE12
		end
	end

	// Bus slave sequencing; reads insert one wait so writes land first
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			addr_q <= 8'h00;
			size_ok_q <= 1'b0;
			hready_q <= 1'b1;
		end else begin
			case (state_q)
				ST_RD_WAIT: begin
					// Read data is being formed; release the bus next
					hready_q <= 1'b1;
					state_q <= ST_RD_DONE;
				end
				default: begin
					// Idle, write data or read data phase: accept a new address
					if (take_addr) begin
						addr_q <= haddr_i[7:0];
						size_ok_q <= (hsize_i == 3'h2);
						if (hwrite_i) begin
							state_q <= ST_WRITE;
						end else begin
							hready_q <= 1'b0;
							state_q <= ST_RD_WAIT;
						end
					end else begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Register writes in the write data phase
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			port_output_latch_q <= `RST_LATCH;
			port_direction_q <= `RST_DIRECTION; // RULE16
			segment_enable_group_five_q <= `RST_SEGMENT_ENABLE;
			analog_select_low_q <= `RST_ANALOG_LOW; // RULE16
			analog_select_high_q <= `RST_ANALOG_HIGH; // RULE11
			hiz_config_q <= `RST_HIZ_CONFIG;
		end else if (state_q == ST_WRITE && size_ok_q && PORT_PRESENT) begin
			// Offset decode; unmapped writes are dropped
			if (addr_q == `OFS_PIN_LEVEL) begin
				port_output_latch_q <= hwdata_i[PIN_COUNT-1:0]; // RULE4
			end else if (addr_q == `OFS_OUTPUT_LATCH) begin
				port_output_latch_q <= hwdata_i[PIN_COUNT-1:0]; // RULE2
			end else if (addr_q == `OFS_DIRECTION) begin
				port_direction_q <= hwdata_i[PIN_COUNT-1:0]; // RULE1
			end else if (addr_q == `OFS_SEGMENT_ENABLE) begin
				segment_enable_group_five_q <= hwdata_i[7:0]; // RULE5
			end else if (addr_q == `OFS_ANALOG_LOW) begin
				analog_select_low_q <= hwdata_i[7:0];
			end else if (addr_q == `OFS_ANALOG_HIGH) begin
				analog_select_high_q <= hwdata_i[7:0];
			end else if (addr_q == `OFS_HIZ_CONFIG) begin
				hiz_config_q <= {6'h00, hwdata_i[1:0]};
			end
		end
	end

	// Read data formed in the wait cycle from settled registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			hrdata_q <= 32'h00000000;
		end else if (state_q == ST_RD_WAIT) begin
			// An absent port reads as zero everywhere
			if (!PORT_PRESENT) begin
				hrdata_q <= 32'h00000000; // RULE14
			end else if (addr_q == `OFS_PIN_LEVEL) begin
				hrdata_q <= {24'h000000, pin_level_q}; // RULE3
			end else if (addr_q == `OFS_OUTPUT_LATCH) begin
				hrdata_q <= {24'h000000, port_output_latch_q}; // RULE15
			end else if (addr_q == `OFS_DIRECTION) begin
				hrdata_q <= {24'h000000, port_direction_q};
			end else if (addr_q == `OFS_SEGMENT_ENABLE) begin
				hrdata_q <= {24'h000000, segment_enable_group_five_q};
			end else if (addr_q == `OFS_ANALOG_LOW) begin
				hrdata_q <= {24'h000000, analog_select_low_q};
			end else if (addr_q == `OFS_ANALOG_HIGH) begin
				hrdata_q <= {24'h000000, analog_select_high_q};
			end else if (addr_q == `OFS_HIZ_CONFIG) begin
				hrdata_q <= {24'h000000, hiz_config_q};
			end else begin
				// Unmapped offsets read zero with OKAY
				hrdata_q <= 32'h00000000;
			end
		end
	end

	// Pin drivers registered so outputs come from flops
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_o_q <= '0;
			pin_oe_q <= '0; // RULE16
		end else if (!PORT_PRESENT) begin
			// Smaller configuration: nothing reaches the pins
			pin_o_q <= '0; // RULE14
			pin_oe_q <= '0;
		end else begin
			pin_o_q <= pm.drv_val;
			pin_oe_q <= pm.drv_en; // RULE3
		end
	end

	// Peripheral inputs taken from the pins
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			nine_cap_q <= 1'b0;
			eight_cap_q <= 1'b0;
			comp_c_q <= 1'b0;
			comp_d_q <= 1'b0;
		end else begin
			// Capture only in input direction and with the segment off
			nine_cap_q <= PORT_PRESENT & port_direction_q[`BIT_CAPCOMP_NINE] &
				!seg_en_pin[`BIT_CAPCOMP_NINE] & pin_i[`BIT_CAPCOMP_NINE]; // RULE9
			eight_cap_q <= PORT_PRESENT & port_direction_q[`BIT_CAPCOMP_EIGHT] &
				!seg_en_pin[`BIT_CAPCOMP_EIGHT] & pin_i[`BIT_CAPCOMP_EIGHT]; // RULE9
			// Comparator ignores direction; a segment still cuts it off
			comp_c_q <= PORT_PRESENT & !seg_en_pin[`BIT_CAPCOMP_NINE] &
				pin_i[`BIT_CAPCOMP_NINE]; // RULE13
			comp_d_q <= PORT_PRESENT & !seg_en_pin[`BIT_CAPCOMP_EIGHT] &
				pin_i[`BIT_CAPCOMP_EIGHT]; // RULE13
		end
	end

	// Analog selects per pin, dropped while a segment owns the pin
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			analog_sel_q <= '0;
		end else if (!PORT_PRESENT) begin
			analog_sel_q <= '0; // RULE14
		end else begin
			analog_sel_q <= ana_pin & ~seg_en_pin; // RULE7
		end
	end

	// Output ports
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o = 1'b0;
	assign pin_o = pin_o_q;
	assign pin_oe_o = pin_oe_q;
	assign capcomp_channel_nine_capture_o = nine_cap_q;
	assign capcomp_channel_eight_capture_o = eight_cap_q;
	assign comparator_two_in_c_o = comp_c_q;
	assign comparator_two_in_d_o = comp_d_q;
	assign analog_sel_o = analog_sel_q;
endmodule
`default_nettype wire

//--- bench/port_board_model.sv
// Board-side model that resolves each port pin from port drive and board source
`timescale 1ns/1ns
`default_nettype none
module port_board_model (
	// Port drive
	input wire logic [7:0] drive_i,
	input wire logic [7:0] drive_en_i,
	// Board source, seen only where the port lets go
	input wire logic [7:0] ext_i,
	// Resolved pin levels
	output logic [7:0] level_o
);
	// No pull resistors on this board, so a released pin shows the board source
	assign level_o = (drive_en_i & drive_i) | (~drive_en_i & ext_i);
endmodule
`default_nettype wire

//--- bench/gpio_port_segmux_asserts.sv
// Port-level assertions for the segment-muxed port
`timescale 1ns/1ns
`default_nettype none
module gpio_port_segmux_asserts #(
	parameter bit PORT_PRESENT = 1'b1,
	parameter int PIN_COUNT = 8
) (
	// Watched ports
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire port_pkg::word_t hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [PIN_COUNT-1:0] pin_i,
	input wire logic [PIN_COUNT-1:0] pin_oe_o,
	input wire logic capcomp_channel_nine_capture_o,
	input wire logic comparator_two_in_c_o,
	input wire logic comparator_two_in_d_o,
	input wire logic [PIN_COUNT-1:0] analog_sel_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Transfers taken by the slave
	wire logic take = hsel_i && htrans_i[1] && hready_i;
	rsp_okay_a: assert property (hresp_o == 1'b0) else $error("response not okay");
	read_wait_a: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	write_nowait_a: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	rdata_upper_a: assert property (hrdata_o[31:8] == 24'h0) else $error("upper data set");
	rdata_hold_a: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
		else $error("read data moved");
	cmp_c_a: assert property (comparator_two_in_c_o |-> $past(pin_i[4]) || $past(pin_i[4], 2))
		else $error("comparator c without pin");
	cmp_d_a: assert property (comparator_two_in_d_o |-> $past(pin_i[5]) || $past(pin_i[5], 2))
		else $error("comparator d without pin");
	cap_nine_a: assert property (capcomp_channel_nine_capture_o |-> comparator_two_in_c_o)
		else $error("capture without comparator path");
	reset_analog_a: assert property ($fell(rst_i) |-> ##1 analog_sel_o == {PIN_COUNT{1'b1}}
		&& pin_oe_o == '0) else $error("reset defaults wrong");
	// Main scenarios reached
	cover property (take && !hwrite_i);
	cover property (capcomp_channel_nine_capture_o);
	cover property (comparator_two_in_d_o);
endmodule
bind gpio_port_segmux gpio_port_segmux_asserts #(.PORT_PRESENT(PORT_PRESENT),
	.PIN_COUNT(PIN_COUNT)) gpio_port_segmux_asserts_inst (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.pin_i(pin_i), .pin_oe_o(pin_oe_o),
	.capcomp_channel_nine_capture_o(capcomp_channel_nine_capture_o),
	.comparator_two_in_c_o(comparator_two_in_c_o),
	.comparator_two_in_d_o(comparator_two_in_d_o), .analog_sel_o(analog_sel_o));
`default_nettype wire

//--- bench/tb_gpio_port_segmux.sv
// Self-checking bench for the segment-muxed port
`timescale 1ns/1ns
`default_nettype none
`include "port_cfg.svh"
module tb_gpio_port_segmux;
	import port_pkg::*;
	logic sys_clk_i = 1'b0; // Bench clock
	logic rst_i = 1'b1; // Held at start
	logic hsel_i = 1'b0, hwrite_i = 1'b0, hreadyout_o, hresp_o;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	word_t haddr_i = '0, hwdata_i = '0, hrdata_o;
	logic [7:0] pin_i, pin_o, pin_oe_o, analog_sel_o;
	logic [7:0] ext_q = 8'h00, seg_q = 8'h00; // Board source and segment drives
	logic [8:0] per_q = 9'h000; // Capcomp, PWM and shutdown inputs
	logic cap9, cap8, cmp_c, cmp_d;
	int regs[7]; // Register model, index is offset over four
	int num_errors = 0, total_checks = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	gpio_port_segmux gpio_port_segmux_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .segment_drive_i(seg_q),
		.capcomp_channel_nine_out_i(per_q[0]), .capcomp_channel_nine_en_i(per_q[1]),
		.capcomp_channel_eight_out_i(per_q[2]), .capcomp_channel_eight_en_i(per_q[3]),
		.capcomp_channel_nine_capture_o(cap9), .capcomp_channel_eight_capture_o(cap8),
		.epwm_three_out_c_i(per_q[4]), .epwm_three_out_c_en_i(per_q[5]),
		.epwm_three_out_b_i(per_q[6]), .epwm_three_out_b_en_i(per_q[7]),
		.epwm_shutdown_i(per_q[8]), .comparator_two_in_c_o(cmp_c),
		.comparator_two_in_d_o(cmp_d), .analog_sel_o(analog_sel_o));
	port_board_model port_board_model_inst (.drive_i(pin_o), .drive_en_i(pin_oe_o),
		.ext_i(ext_q), .level_o(pin_i));
	// Verdict and end of run
	task automatic summarize();
		if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Word comparison
	task automatic chk_word(input word_t got, input word_t exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Pin vector comparison
	task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
		chk_word({24'h0, got}, {24'h0, exp});
	endtask
	// One single AHB-Lite transfer; waits are bounded
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		input logic [2:0] sz, output word_t rd);
		int n;
		n = 0;
		hsel_i <= 1'b1; htrans_i <= 2'h2; haddr_i <= {24'h0, a}; hwrite_i <= wr; hsize_i <= sz;
		do begin @(posedge sys_clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
		hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= {24'h0, wd};
		do begin @(posedge sys_clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
		rd = hrdata_o;
		if (n >= 50) begin num_errors++; summarize(); end
	endtask
	// Expected pins from the model: segment, then peripherals, then latch
	task automatic expect_pins(output logic [7:0] oe, o, lvl, an);
		int k;
		int s;
		for (k = 0; k < 8; k++) begin
			oe[k] = 1'b1;
			// Segment enable bit and segment drive share one index per pin
			s = k < 4 ? 7 - k : k - 4;
			if (regs[3][s]) o[k] = seg_q[s];
			else if (regs[2][k]) begin oe[k] = 1'b0; o[k] = 1'b0; end
			else if (k > 3 && k < 6 && per_q[2*k-7]) o[k] = per_q[2*k-8];
			else if (k > 3 && k < 6 && per_q[2*k-3]) begin
				o[k] = per_q[2*k-4];
				oe[k] = !(per_q[8] && regs[6][k-4]);
			end else o[k] = regs[1][k];
			lvl[k] = oe[k] ? o[k] : ext_q[k];
			an[k] = (k < 4 ? regs[5][7-k] : regs[4][k]) && !regs[3][s];
		end
	endtask
	// Settle, compare the pins, then read back every offset
	task automatic check_all();
		logic [7:0] oe, o, lvl, an;
		word_t rd;
		int r;
		repeat (4) @(posedge sys_clk_i);
		expect_pins(oe, o, lvl, an);
		chk_pins(pin_oe_o, oe);
		chk_pins(pin_o & oe, o & oe);
		chk_pins(analog_sel_o, an);
		chk_pins({4'h0, cap8, cap9, cmp_d, cmp_c}, {4'h0, lvl[5:4] & regs[2][5:4] & ~regs[3][1:0],
			lvl[5:4] & ~regs[3][1:0]});
		for (r = 0; r < 8; r++) begin
			bus(1'b0, 8'(r * 4), 8'h00, 3'h2, rd);
			chk_word(rd, r == 0 ? {24'h0, lvl} : (r == 7 ? 32'h0 : 32'(regs[r])));
		end
	endtask
	// Main sequence
	initial begin
		word_t rd;
		logic [7:0] v;
		int i, r;
		void'($urandom(32'h4209));
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		regs = '{0, `RST_LATCH, `RST_DIRECTION, `RST_SEGMENT_ENABLE, `RST_ANALOG_LOW,
			`RST_ANALOG_HIGH, `RST_HIZ_CONFIG};
		check_all();
		for (i = 0; i < 40; i++) begin
			for (r = 1; r < 7; r++) begin
				v = 8'($urandom);
				bus(1'b1, (r == 1 && v[0]) ? `OFS_PIN_LEVEL : 8'(r * 4), v, 3'h2, rd);
				// Shutdown tristate register keeps only its two low bits
				regs[r] = (r == 6) ? (v & 8'h03) : v;
			end
			bus(1'b1, 8'h1C, 8'($urandom), 3'h2, rd);
			// Unmapped word writes at offsets 0x20 to 0xFC above the map are dropped
			bus(1'b1, 8'(32'h20 + $urandom_range(55) * 4), 8'($urandom), 3'h2, rd);
			ext_q <= 8'($urandom);
			seg_q <= 8'($urandom);
			per_q <= 9'($urandom);
			check_all();
		end
		// Reset again with random configuration in place
		rst_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		regs = '{0, `RST_LATCH, `RST_DIRECTION, `RST_SEGMENT_ENABLE, `RST_ANALOG_LOW,
			`RST_ANALOG_HIGH, `RST_HIZ_CONFIG};
		check_all();
		summarize();
	end
endmodule
`default_nettype wire
